// ===== logic/sso_pkg.sv
//------------------------------------------------------------
// Purpose : constants for the servo status output block
// Assumes : 50 MHz reference clock, speeds in r/min
// Notes   : offsets are byte addresses on the APB slave
//------------------------------------------------------------
package sso_pkg;
  //----------------------------------------------------------
  // timing
  //----------------------------------------------------------
  localparam int CLK_NS         = 20;        // clock period
  localparam int CTRL_PERIOD_NS = 1000000;   // control cycle
  localparam int CTRL_CYCLES    = CTRL_PERIOD_NS / CLK_NS;
  localparam int FAULT_MIN_MS   = 2500;      // earliest fault_out on
  localparam int FAULT_MAX_MS   = 3500;      // latest fault_out on
  localparam int FAULT_DLY_MS   = (FAULT_MIN_MS + FAULT_MAX_MS) / 2;
  localparam int FAULT_DLY_TICKS = (FAULT_DLY_MS * 1000) / (CTRL_PERIOD_NS / 1000);
  //----------------------------------------------------------
  // speed thresholds (r/min)
  //----------------------------------------------------------
  localparam logic [15:0] STILL_HYST   = 16'h0014;  // 20 r/min
  localparam logic [17:0] HIT_BAND     = 18'h00014; // +20 r/min
  localparam logic [16:0] HIT_DIV      = 17'h00014; // 1/0.05
  localparam logic [16:0] HIT_LOW      = 17'h00014; // 20 r/min
  //----------------------------------------------------------
  // register map
  //----------------------------------------------------------
  localparam logic [7:0] REG_PIN_ASSIGN = 8'h00;
  localparam logic [7:0] REG_SETTLE     = 8'h04;
  localparam logic [7:0] REG_STANDSTILL = 8'h08;
  localparam logic [7:0] REG_BRAKE_DLY  = 8'h0c;
  localparam logic [7:0] REG_STATUS     = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT   = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h18;
  localparam int         PIN_FIELD_W    = 4;      // pin k at bits 4k+2:4k
  //----------------------------------------------------------
  // reset values
  //----------------------------------------------------------
  localparam logic [2:0]  PIN0_RST       = 3'h1;  // brake interlock
  localparam logic [2:0]  PIN12_RST      = 3'h0;  // unassigned
  localparam logic [15:0] SETTLE_RST     = 16'h0064;
  localparam logic [15:0] STANDSTILL_RST = 16'h0032; // 50 r/min
  localparam logic [15:0] BRAKE_DLY_RST  = 16'h0000;
  //----------------------------------------------------------
  // function codes for pin assignment
  //----------------------------------------------------------
  localparam logic [2:0] FN_NONE = 3'h0;  // always off
  localparam int         FN_NUM  = 8;
  // control modes
  typedef enum logic [1:0] {
    SSO_MODE_POS, SSO_MODE_SPD, SSO_MODE_TRQ, SSO_MODE_CTRQ
  } sso_mode_e;
  // interrupt bits
  localparam int IRQ_FAULT = 0;  // fault_out fell
  localparam int IRQ_STILL = 1;  // standstill began
  localparam int IRQ_VLIM  = 2;  // speed limit reached
  localparam int IRQ_SETTL = 3;  // position settled
  localparam int IRQ_W     = 4;
endpackage

// ===== logic/sso_pin_mux.sv
//------------------------------------------------------------
// Purpose : pick one status function for an output pin
// Assumes : function vector bit 0 is the constant-off slot
// Notes   : combinational, registered by the caller
//------------------------------------------------------------
`timescale 1ns/1ps
module sso_pin_mux
(
  // selection
  input  wire logic [2:0]                  i_sel,
  input  wire logic [sso_pkg::FN_NUM-1:0]  i_func,
  // chosen level
  output logic                             o_level
);
  // an unassigned pin picks slot 0, which is tied low
  always_comb
  begin
    o_level = (i_sel == sso_pkg::FN_NONE) ? 1'b0 : i_func[i_sel];
  end
endmodule // sso_pin_mux

// ===== logic/sso_status_outputs.sv
//------------------------------------------------------------
// Purpose : servo discrete status outputs with APB registers
// Assumes : drive-state inputs come from logic on i_ref_clk
// Notes   : status and pin outputs change only on the control-cycle tick
//------------------------------------------------------------
// What this block does
// - three pins, each assigned one status function
// - brake interlock off on servo-off or alarm
// - fault_out off when base drive shut
// - fault_out on 2.5-3.5 s after power-on
// - settled while droop within settle range
// - settled only in position control
// - ready on when servo-on and operable
// - speed hit off during servo-off
// - speed hit within preset +-(5% + 20)
// - preset <= 20 r/min keeps hit on
// - speed hit only in speed control
// - speed limit flag when limit reached
// - speed limit flag off when servo off
// - speed limit flag only in torque control
// - standstill on at or below level
// - standstill off at level plus 20
// - same hysteresis in reverse rotation
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sso_status_outputs
#(
  parameter int P_CTRL_CYCLES   = sso_pkg::CTRL_CYCLES,
  parameter int P_FAULT_DLY_TCK = sso_pkg::FAULT_DLY_TICKS
)
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // drive state
  input  wire logic        i_servo_on,
  input  wire logic        i_drive_ok,
  input  wire logic        i_alarm,
  input  wire logic        i_base_shutoff,
  input  wire logic [1:0]  i_mode,
  input  wire logic [31:0] i_droop,
  input  wire logic [15:0] i_speed,
  input  wire logic [15:0] i_preset_speed,
  input  wire logic [15:0] i_speed_limit,
  // status functions
  output logic             o_brake_interlock_out,
  output logic             o_fault_out,
  output logic             o_position_settled_out,
  output logic             o_ready_out,
  output logic             o_target_speed_hit_out,
  output logic             o_speed_limit_active_out,
  output logic             o_standstill_detect_out,
  // assigned pins, delay value, interrupt
  output logic [2:0]       o_pin,
  output logic [15:0]      o_brake_delay_param,
  output logic             o_irq
);
  //----------------------------------------------------------
  // state
  //----------------------------------------------------------
  typedef struct packed {
    logic [31:0]      div_cnt;      // control-cycle divider
    logic [15:0]      pwr_cnt;      // ticks since reset, stops at pwr_done
    logic             pwr_done;     // power-on wait over
    logic [2:0][2:0]  pin_sel;      // out_pin0..2_assign
    logic [15:0]      settle_range; // settle_range_param
    logic [15:0]      still_level;  // standstill_level_param
    logic [15:0]      brake_dly;    // brake_delay_param
    logic [3:0]       irq_stat;     // sticky events
    logic [3:0]       irq_mask;     // interrupt enables
    logic [31:0]      rdata;        // read data for access phase
    logic             err;          // unmapped address seen
    logic             brake;
    logic             fault;
    logic             settled;
    logic             ready;
    logic             hit;
    logic             vlim;
    logic             still;
    logic [2:0]       pins;
  } sso_state_s;

  sso_state_s st;        // registered state
  sso_state_s next_st;   // next state

  //----------------------------------------------------------
  // helpers
  //----------------------------------------------------------
  // magnitude of a signed 16-bit speed
  function automatic logic [16:0] sso_abs16(input logic [15:0] v);
    logic [16:0] e;
    e = {v[15], v};
    return v[15] ? 17'(-e) : e;
  endfunction

  // word-aligned register decode, used for read and write
  function automatic logic sso_hit(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= sso_pkg::REG_IRQ_MASK);
  endfunction

  logic              tick;       // one control cycle elapsed
  logic [16:0]       spd_abs;    // |speed|
  logic [16:0]       pre_abs;    // |preset|
  logic signed [17:0] sdiff;     // speed - preset
  logic [17:0]       diff_abs;   // |speed - preset|
  logic [17:0]       hit_tol;    // preset/20 + 20
  logic [32:0]       droop_abs;  // |droop|
  logic [16:0]       still_on;   // on level
  logic [16:0]       still_off;  // off level
  logic              in_pos;     // mode checks
  logic              in_spd;
  logic              in_trq;
  logic [sso_pkg::FN_NUM-1:0] fn_vec; // next function levels
  logic [2:0]        pin_lvl;    // mux results
  logic              acc;        // apb access phase
  logic [31:0]       status_w;   // live status word
  logic              next_brake, next_fault, next_settled, next_ready; // tick levels
  logic              next_hit, next_vlim, next_still;

  //----------------------------------------------------------
  // arithmetic on the drive state
  //----------------------------------------------------------
  always_comb
  begin
    tick      = (st.div_cnt == 32'(P_CTRL_CYCLES - 1));
    spd_abs   = sso_abs16(i_speed);
    pre_abs   = sso_abs16(i_preset_speed);
    sdiff     = 18'(signed'(i_speed)) - 18'(signed'(i_preset_speed));
    diff_abs  = sdiff[17] ? 18'(-sdiff) : 18'(sdiff);
    hit_tol   = 18'(pre_abs / sso_pkg::HIT_DIV) + sso_pkg::HIT_BAND;
    droop_abs = i_droop[31] ? 33'(-{1'b1, i_droop}) : {1'b0, i_droop};
    // symmetric levels: magnitude covers both directions
    still_on  = {1'b0, st.still_level};
    still_off = 17'(still_on + {1'b0, sso_pkg::STILL_HYST});
    in_pos    = (i_mode == sso_pkg::SSO_MODE_POS);
    in_spd    = (i_mode == sso_pkg::SSO_MODE_SPD);
    in_trq    = (i_mode == sso_pkg::SSO_MODE_TRQ);
    acc       = i_psel && i_penable;
    // levels kept apart from next_st so the pin muxes never feed themselves
    // brake released only while on and healthy
    next_brake   = i_servo_on && !i_alarm;
    // fault_out high means no fault
    next_fault   = st.pwr_done && !i_alarm && !i_base_shutoff;
    // droop window, position control only
    next_settled = in_pos && (droop_abs <= {17'h0, st.settle_range});
    // ready to operate
    next_ready   = i_servo_on && i_drive_ok && !i_alarm;
    // speed band or slow preset, speed mode only
    next_hit     = in_spd && i_servo_on &&
                   ((pre_abs <= sso_pkg::HIT_LOW) || (diff_abs <= hit_tol));
    // speed limit in torque mode, off at servo-off
    next_vlim    = in_trq && i_servo_on && (spd_abs >= {1'b0, i_speed_limit});
    // standstill with hysteresis, held between the levels
    next_still   = st.still;
    if (spd_abs <= still_on)
      next_still = 1'b1;
    else if (spd_abs >= still_off)
      next_still = 1'b0;
  end

  //----------------------------------------------------------
  // pin routing
  //----------------------------------------------------------
  // slot order is the function code seen by software
  assign fn_vec = {next_still, next_vlim, next_hit,
                   next_ready, next_settled, next_fault,
                   next_brake, 1'b0};

  // one selector per pin
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin
      sso_pin_mux u_mux
      (
        .i_sel   (st.pin_sel[g]),
        .i_func  (fn_vec),
        .o_level (pin_lvl[g])
      );
    end
  endgenerate

  //----------------------------------------------------------
  // next state
  //----------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // free-running control-cycle divider
    next_st.div_cnt = tick ? 32'h0 : 32'(st.div_cnt + 32'h1);

    // all functions settle together on the tick
    if (tick)
    begin
      // power-on wait counted in control cycles
      if (!st.pwr_done)
      begin
        next_st.pwr_cnt  = 16'(st.pwr_cnt + 16'h1);
        next_st.pwr_done = (st.pwr_cnt == 16'(P_FAULT_DLY_TCK - 1));
      end
      // flags and pins take the same evaluation
      next_st.brake   = next_brake;
      next_st.fault   = next_fault;
      next_st.settled = next_settled;
      next_st.ready   = next_ready;
      next_st.hit     = next_hit;
      next_st.vlim    = next_vlim;
      next_st.still   = next_still;
      next_st.pins    = pin_lvl;
    end

    // apb setup phase: decode and capture read data
    if (i_psel && !i_penable)
    begin
      next_st.err   = !sso_hit(i_paddr);
      next_st.rdata = 32'h0;
      case (i_paddr)
        sso_pkg::REG_PIN_ASSIGN:
          next_st.rdata = {20'h0, 1'b0, st.pin_sel[2], 1'b0,
                           st.pin_sel[1], 1'b0, st.pin_sel[0]};
        sso_pkg::REG_SETTLE:     next_st.rdata = {16'h0, st.settle_range};
        sso_pkg::REG_STANDSTILL: next_st.rdata = {16'h0, st.still_level};
        sso_pkg::REG_BRAKE_DLY:  next_st.rdata = {16'h0, st.brake_dly};
        sso_pkg::REG_STATUS:     next_st.rdata = status_w;
        sso_pkg::REG_IRQ_STAT:   next_st.rdata = {28'h0, st.irq_stat};
        sso_pkg::REG_IRQ_MASK:   next_st.rdata = {28'h0, st.irq_mask};
        default:                 next_st.rdata = 32'h0;
      endcase
    end

    // apb access phase: writes to mapped registers
    if (acc && i_pwrite && sso_hit(i_paddr))
    begin
      case (i_paddr)
        sso_pkg::REG_PIN_ASSIGN:
        begin
          next_st.pin_sel[0] = i_pwdata[2:0];
          next_st.pin_sel[1] = i_pwdata[6:4];
          next_st.pin_sel[2] = i_pwdata[10:8];
        end
        sso_pkg::REG_SETTLE:     next_st.settle_range = i_pwdata[15:0];
        sso_pkg::REG_STANDSTILL: next_st.still_level  = i_pwdata[15:0];
        // stored for the neighbouring shut-off sequence
        sso_pkg::REG_BRAKE_DLY:  next_st.brake_dly    = i_pwdata[15:0];
        sso_pkg::REG_IRQ_STAT:
          next_st.irq_stat = st.irq_stat & ~i_pwdata[3:0];
        sso_pkg::REG_IRQ_MASK:   next_st.irq_mask     = i_pwdata[3:0];
        default:                 next_st.irq_mask     = st.irq_mask;
      endcase
    end

    // events come last so a set beats a same-cycle clear
    if (tick)
    begin
      if (st.fault && !next_st.fault)
        next_st.irq_stat[sso_pkg::IRQ_FAULT] = 1'b1;
      if (!st.still && next_st.still)
        next_st.irq_stat[sso_pkg::IRQ_STILL] = 1'b1;
      if (!st.vlim && next_st.vlim)
        next_st.irq_stat[sso_pkg::IRQ_VLIM]  = 1'b1;
      if (!st.settled && next_st.settled)
        next_st.irq_stat[sso_pkg::IRQ_SETTL] = 1'b1;
    end
  end

  //----------------------------------------------------------
  // state register
  //----------------------------------------------------------
  // synchronous reset; outputs start low, fault_out waits
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      st              <= '0;
      st.pin_sel[0]   <= sso_pkg::PIN0_RST;
      st.pin_sel[1]   <= sso_pkg::PIN12_RST;
      st.pin_sel[2]   <= sso_pkg::PIN12_RST;
      st.settle_range <= sso_pkg::SETTLE_RST;
      st.still_level  <= sso_pkg::STANDSTILL_RST;
      st.brake_dly    <= sso_pkg::BRAKE_DLY_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------
  // outputs
  //----------------------------------------------------------
  assign status_w = {24'h0, st.pwr_done, st.still, st.vlim, st.hit,
                     st.ready, st.settled, st.fault, st.brake};
  assign o_prdata  = st.rdata;
  assign o_pready  = acc;              // zero wait states
  assign o_pslverr = acc && st.err;
  assign o_brake_interlock_out    = st.brake;
  assign o_fault_out              = st.fault;
  assign o_position_settled_out   = st.settled;
  assign o_ready_out              = st.ready;
  assign o_target_speed_hit_out   = st.hit;
  assign o_speed_limit_active_out = st.vlim;
  assign o_standstill_detect_out  = st.still;
  assign o_pin                    = st.pins;
  assign o_brake_delay_param      = st.brake_dly;
  assign o_irq = |(st.irq_stat & st.irq_mask);

  //----------------------------------------------------------
  // assertions
  //----------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  brake_off_a: assert property (tick && (!i_servo_on || i_alarm) |=>
    !o_brake_interlock_out) else $error("brake not released off");
  fault_shut_a: assert property (tick && i_base_shutoff |=>
    !o_fault_out) else $error("fault_out high at shutoff");
  fault_wait_a: assert property (!st.pwr_done |-> !o_fault_out)
    else $error("fault_out before power-on wait");
  settle_mode_a: assert property (tick && !in_pos |=>
    !o_position_settled_out) else $error("settled outside pos mode");
  ready_on_a: assert property (tick && i_servo_on && i_drive_ok &&
    !i_alarm |=> o_ready_out) else $error("ready missing");
  hit_off_a: assert property (tick && (!i_servo_on || !in_spd) |=>
    !o_target_speed_hit_out) else $error("speed hit while off");
  hit_low_a: assert property (tick && in_spd && i_servo_on &&
    pre_abs <= 17'h14 |=> o_target_speed_hit_out) else $error("slow preset");
  vlim_on_a: assert property (tick && in_trq && i_servo_on &&
    spd_abs >= {1'b0, i_speed_limit} |=> o_speed_limit_active_out)
    else $error("speed limit flag missing");
  still_hold_a: assert property (tick && o_standstill_detect_out &&
    spd_abs < still_off |=> o_standstill_detect_out)
    else $error("standstill dropped early");
  still_on_a: assert property (tick && spd_abs <= still_on |=>
    o_standstill_detect_out) else $error("standstill missing");
  pin_quiet_a: assert property (o_pin != $past(o_pin) |->
    $past(tick)) else $error("pin changed off tick");

  power_up_c: cover property (!o_fault_out ##1 o_fault_out);
  still_cyc_c: cover property (o_standstill_detect_out ##1
    !o_standstill_detect_out);
  irq_c: cover property (!o_irq ##1 o_irq);
endmodule // sso_status_outputs

// ===== tb/sso_brake_relay.sv
//------------------------------------------------------------
// Purpose : brake relay model driven by an assigned status pin
// Assumes : coil is the pin level, high = energised
// Notes   : pick-up takes P_PICKUP clocks, drop-out takes one clock
//------------------------------------------------------------
`timescale 1ns/1ps
module sso_brake_relay
#(
  parameter int P_PICKUP = 3  // coil pick-up time in clocks
)
(
  // clock
  input  wire logic i_ref_clk,
  // coil drive from the amplifier pin
  input  wire logic i_coil,
  // brake released, shaft free to turn
  output logic      o_released
);
  int cnt = 0;  // clocks the coil has been energised
  //----------------------------------------------------------
  // relay armature
  //----------------------------------------------------------
  // drop-out comes on the next clock so a late brake never hides a slow interlock
  always @(posedge i_ref_clk)
  begin
    if (i_coil !== 1'b1)
      cnt <= 0;
    else if (cnt < P_PICKUP)
      cnt <= cnt + 1;
  end
  assign o_released = (cnt >= P_PICKUP);
endmodule // sso_brake_relay

// ===== tb/testbench.sv
//------------------------------------------------------------
// Purpose : self-checking bench for the status output block
// Assumes : short control cycle of 4 clocks, power-up 5 ticks
// Notes   : inputs driven at rising edges, outputs read at falling
//------------------------------------------------------------
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, droop = 32'h0, rd;
  logic        pready, pslverr, servo = 0, ok = 0, alarm = 0, shut = 0, err;
  logic [1:0]  mode = 2'h0;
  logic [15:0] speed = 16'h0, preset = 16'h0, lim = 16'h0, bdly;
  logic        brk, flt, stl, rdy, hit, speed_limit_active_out, standstill_detect_out, irq, rel;
  logic [2:0]  pin;
  int          num_errors = 0, checked = 0;
  //----------------------------------------------------------
  // clock, design and relay model
  //----------------------------------------------------------
  always #10 clk = ~clk;
  sso_status_outputs #(.P_CTRL_CYCLES(4), .P_FAULT_DLY_TCK(5)) sso_status_outputs_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_servo_on(servo), .i_drive_ok(ok), .i_alarm(alarm),
    .i_base_shutoff(shut), .i_mode(mode), .i_droop(droop), .i_speed(speed),
    .i_preset_speed(preset), .i_speed_limit(lim), .o_brake_interlock_out(brk),
    .o_fault_out(flt), .o_position_settled_out(stl), .o_ready_out(rdy),
    .o_target_speed_hit_out(hit), .o_speed_limit_active_out(speed_limit_active_out),
    .o_standstill_detect_out(standstill_detect_out), .o_pin(pin), .o_brake_delay_param(bdly), .o_irq(irq));
  sso_brake_relay sso_brake_relay_i (.i_ref_clk(clk), .i_coil(pin[0]), .o_released(rel));
  //----------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50)
    begin
      chk("pready", 32'h1, 32'h0);
      report_and_stop;
    end
    psel <= 1'b0; pen <= 1'b0;
  endtask
  // let ten clocks (two and a half control cycles) pass, then read at the falling edge
  task automatic settle;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic spd(input logic [15:0] v);
    @(posedge clk);
    speed <= v;
    settle;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //----------------------------------------------------------
  // scenarios
  //----------------------------------------------------------
  task automatic t_power_up;  // fault output timing, then register reset values
    repeat (18) @(posedge clk);
    @(negedge clk);
    chk("fault early", 32'h0, 32'(flt));
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("fault late", 32'h1, 32'(flt));
    apb(0, 8'h00, 0); chk("pin assign", 32'h1, rd);
    apb(0, 8'h04, 0); chk("settle range", 32'h64, rd);
    apb(0, 8'h08, 0); chk("standstill lvl", 32'h32, rd);
    apb(0, 8'h1c, 0); chk("unmapped err", 32'h1, 32'(err));
  endtask
  task automatic t_fault_irq;  // base shutoff drops fault and latches an event
    @(posedge clk); shut <= 1'b1;
    settle;
    chk("fault off", 32'h0, 32'(flt));
    chk("irq masked", 32'h0, 32'(irq));
    apb(1, 8'h18, 32'h1);
    @(negedge clk); chk("irq on", 32'h1, 32'(irq));
    apb(1, 8'h14, 32'hf);
    @(negedge clk); chk("irq cleared", 32'h0, 32'(irq));
    @(posedge clk); shut <= 1'b0;
  endtask
  task automatic t_brake;  // interlock, ready and the relay behind pin 0
    @(posedge clk); servo <= 1'b1; ok <= 1'b1;
    settle;
    chk("brake on", 32'h1, 32'(brk));
    chk("pin0 brake", 32'h1, 32'(pin));
    chk("relay open", 32'h1, 32'(rel));
    chk("ready", 32'h1, 32'(rdy));
    @(posedge clk); alarm <= 1'b1;
    settle;
    chk("brake alarm", 32'h0, 32'(brk));
    chk("relay shut", 32'h0, 32'(rel));
    @(posedge clk); alarm <= 1'b0; servo <= 1'b0;
    settle;
    chk("brake servo off", 32'h0, 32'(brk));
    chk("ready off", 32'h0, 32'(rdy));
    apb(1, 8'h0c, 32'h1234);
    @(negedge clk);
    chk("brake delay", 32'h1234, 32'(bdly));
  endtask
  task automatic t_speed_hit;  // band of preset +-(5% + 20) and its gating
    @(posedge clk); servo <= 1'b1; mode <= 2'h1; preset <= 16'h03e8;
    spd(16'h042e); chk("hit edge", 32'h1, 32'(hit));
    spd(16'h042f); chk("hit out", 32'h0, 32'(hit));
    spd(16'h03a2); chk("hit low edge", 32'h1, 32'(hit));
    @(posedge clk); preset <= 16'h0014;
    spd(16'h01f4); chk("hit slow preset", 32'h1, 32'(hit));
    @(posedge clk); mode <= 2'h0;
    settle; chk("hit pos mode", 32'h0, 32'(hit));
    @(posedge clk); mode <= 2'h1; servo <= 1'b0;
    settle; chk("hit servo off", 32'h0, 32'(hit));
  endtask
  task automatic t_speed_limit;  // limit flag in torque control only
    @(posedge clk); servo <= 1'b1; mode <= 2'h2; lim <= 16'h012c;
    spd(16'h012c); chk("vlim at", 32'h1, 32'(speed_limit_active_out));
    spd(16'h012b); chk("vlim below", 32'h0, 32'(speed_limit_active_out));
    spd(16'h012c); @(posedge clk); servo <= 1'b0;
    settle; chk("vlim servo off", 32'h0, 32'(speed_limit_active_out));
    @(posedge clk); servo <= 1'b1; mode <= 2'h1;
    settle; chk("vlim spd mode", 32'h0, 32'(speed_limit_active_out));
  endtask
  task automatic t_standstill;  // hysteresis both ways, pins 1 and 2 reassigned
    apb(1, 8'h00, 32'h271);
    spd(16'h0200); chk("zsp fast", 32'h0, 32'(standstill_detect_out));
    spd(16'h0033); chk("zsp 51", 32'h0, 32'(standstill_detect_out));
    spd(16'h0032); chk("zsp 50", 32'h1, 32'(standstill_detect_out));
    chk("pin1 zsp", 32'h1, 32'(pin[1]));
    chk("pin2 fault", 32'h1, 32'(pin[2]));
    spd(16'h0045); chk("zsp 69", 32'h1, 32'(standstill_detect_out));
    spd(16'h0046); chk("zsp 70", 32'h0, 32'(standstill_detect_out));
    spd(16'hffce); chk("zsp -50", 32'h1, 32'(standstill_detect_out));
    spd(16'hffbb); chk("zsp -69", 32'h1, 32'(standstill_detect_out));
    spd(16'hffba); chk("zsp -70", 32'h0, 32'(standstill_detect_out));
  endtask
  task automatic t_settled;  // droop window, position control only
    @(posedge clk); mode <= 2'h0; droop <= 32'hffffff9c;
    settle; chk("settled -100", 32'h1, 32'(stl));
    @(posedge clk); droop <= 32'h65;
    settle; chk("settled 101", 32'h0, 32'(stl));
    @(posedge clk); droop <= 32'h64; mode <= 2'h3;
    settle; chk("settled ctrq", 32'h0, 32'(stl));
  endtask
  //----------------------------------------------------------
  // main sequence and watchdog
  //----------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_power_up;
    t_fault_irq;
    t_brake;
    t_speed_hit;
    t_speed_limit;
    t_standstill;
    t_settled;
    report_and_stop;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
endmodule // testbench
